// ==== src/epiu_pkg.sv ====
// What this block does
// - pins driven as outputs still raise requests
// - any unmasked watched pin toggle raises request
// - pin change detection works without I/O clock
// - line six edges need running I/O clock
// - low level and lines 0-3 edges asynchronous
// - I/O clock stops outside idle sleep
// - level mode requests while pin stays low
// - vanished wake level gives no interrupt
// - lines 0-3 sense: low, any, fall, rise
// - line six sense: low, change, fall, rise
// - second sense register reserved bits read zero
// - line enabled only with mask and global enable
// - trigger sets flag; vector or write-one clears
// - flag held clear in level sense mode
// - sleep with lines disabled may set flags
// - pin change needs group enable and global enable
// - pin change sets flag; vector or write-one clears
// - per-pin mask bits gate change detection
// - lines 0-3 edges caught above minimum width
package epiu_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFF_SENSE_A = 3'h0;
	localparam logic [2:0] OFF_SENSE_B = 3'h1;
	localparam logic [2:0] OFF_LINE_MASK = 3'h2;
	localparam logic [2:0] OFF_LINE_FLAGS = 3'h3;
	localparam logic [2:0] OFF_PC_CTRL = 3'h4;
	localparam logic [2:0] OFF_PC_FLAGS = 3'h5;
	localparam logic [2:0] OFF_PC_MASK = 3'h6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_LANES = 5'h00;
	localparam logic RST_BIT = 1'b0;
	localparam logic RST_PIN_LEVEL = 1'b1;
	localparam logic [7:0] RST_PINS = 8'hFF;
	localparam int SIX_SENSE_LSB = 4;
	localparam int SYNC_W = 13;
	localparam int LANES = 5;
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	localparam int CLK_PERIOD_NS = 40;
	localparam int PULSE_MIN_NS = 50;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== src/epiu_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module epiu_sync #(
	parameter int WIDTH = 13
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '1;
			sync_out <= '1;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // epiu_sync
`default_nettype wire

// ==== src/epiu_sense.sv ====
`timescale 1ns/1ps
`default_nettype none
module epiu_sense (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sample_en,
	input wire logic level,
	input wire logic [1:0] sense,
	output logic hit
);
	logic prev;

	// prev only moves on a sample, so an edge whose level lasts until the clock restarts is still seen
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= epiu_pkg::RST_PIN_LEVEL;
		end else if (sample_en) begin
			prev <= level;
		end
	end

	always_comb begin
		hit = 1'b0;
		if (sample_en) begin
			case (sense)
				epiu_pkg::SENSE_ANY: hit = level != prev;
				epiu_pkg::SENSE_FALL: hit = prev && !level;
				epiu_pkg::SENSE_RISE: hit = !prev && level;
				default: hit = 1'b0;
			endcase
		end
	end
endmodule // epiu_sense
`default_nettype wire

// ==== src/epiu_top.sv ====
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module epiu_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] ext_lines_zero_to_three,
	input wire logic ext_line_six,
	input wire logic [7:0] change_watch_pins,
	input wire logic global_int_enable,
	input wire logic io_clk_run,
	input wire logic sleep_active,
	input wire logic [7:0] line_vector_taken,
	input wire logic pin_change_vector_taken,
	output logic [7:0] ext_line_request,
	output logic pin_change_request,
	output logic wake_request
);
	logic [7:0] ext_sense_ctrl_a;
	logic [1:0] line_six_sense_select;
	logic [4:0] line_mask;
	logic [4:0] ext_line_flag;
	logic pin_change_group_enable;
	logic pin_change_flag;
	logic [7:0] pin_change_mask;
	logic [12:0] sync_lines;
	logic [3:0] s_low;
	logic s_six;
	logic [7:0] s_pc;
	logic [7:0] pc_prev;
	logic [4:0] lane_level;
	logic [4:0] lane_hit;
	logic [4:0] lane_low_mode;
	logic [4:0] lane_clr;
	logic [4:0] lane_req;
	logic [4:0] next_flag;
	logic [9:0] lane_sense;
	logic pc_hit;
	logic pc_clr;
	logic next_pc_flag;
	logic [7:0] next_rdata;

	function automatic logic [7:0] lanes_to_byte(input logic [4:0] l);
		lanes_to_byte = {1'b0, l[4], 2'b00, l[3:0]};
	endfunction

	function automatic logic [4:0] byte_to_lanes(input logic [7:0] b);
		byte_to_lanes = {b[6], b[3:0]};
	endfunction

	function automatic logic reg_write(input logic [2:0] off);
		reg_write = reg_wr && (reg_addr == off);
	endfunction

	// pins are read back as levels whatever their direction, so a
	// pin driven by this chip triggers like any other
	epiu_sync #(
		.WIDTH(epiu_pkg::SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({change_watch_pins, ext_line_six, ext_lines_zero_to_three}),
		.sync_out(sync_lines)
	);

	assign s_low = sync_lines[3:0];
	assign s_six = sync_lines[4];
	assign s_pc = sync_lines[12:5];

	// input buffers of masked-off low lines shut in sleep and read low
	always_comb begin
		lane_level[3:0] = s_low & ~({4{sleep_active}} & ~line_mask[3:0]);
		lane_level[4] = s_six;
	end

	assign lane_sense = {line_six_sense_select, ext_sense_ctrl_a};

	genvar gi;
	generate
		for (gi = 0; gi < epiu_pkg::LANES; gi++) begin : g_lane
			epiu_sense u_sense (
				.core_clk(core_clk),
				.rst_n(rst_n),
				// line six only samples while the I/O clock runs
				.sample_en((gi == epiu_pkg::LANES - 1) ? io_clk_run : 1'b1),
				.level(lane_level[gi]),
				.sense(lane_sense[2*gi+1:2*gi]),
				.hit(lane_hit[gi])
			);
			assign lane_low_mode[gi] = lane_sense[2*gi+1:2*gi] == epiu_pkg::SENSE_LOW;
		end
	endgenerate

	// sense, mask and pin change control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_sense_ctrl_a <= epiu_pkg::RST_BYTE;
		end else if (reg_write(epiu_pkg::OFF_SENSE_A)) begin
			ext_sense_ctrl_a <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_six_sense_select <= epiu_pkg::SENSE_LOW;
		end else if (reg_write(epiu_pkg::OFF_SENSE_B)) begin
			line_six_sense_select <= reg_wdata[epiu_pkg::SIX_SENSE_LSB+:2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_mask <= epiu_pkg::RST_LANES;
		end else if (reg_write(epiu_pkg::OFF_LINE_MASK)) begin
			line_mask <= byte_to_lanes(reg_wdata);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_group_enable <= epiu_pkg::RST_BIT;
		end else if (reg_write(epiu_pkg::OFF_PC_CTRL)) begin
			pin_change_group_enable <= reg_wdata[0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_mask <= epiu_pkg::RST_BYTE;
		end else if (reg_write(epiu_pkg::OFF_PC_MASK)) begin
			pin_change_mask <= reg_wdata;
		end
	end

	// line flags: a set in the clearing cycle wins
	always_comb begin
		lane_clr = byte_to_lanes(line_vector_taken);
		if (reg_write(epiu_pkg::OFF_LINE_FLAGS)) begin
			lane_clr = lane_clr | byte_to_lanes(reg_wdata);
		end
		next_flag = (ext_line_flag & ~lane_clr) | lane_hit;
		next_flag = next_flag & ~lane_low_mode;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_line_flag <= epiu_pkg::RST_LANES;
		end else begin
			ext_line_flag <= next_flag;
		end
	end

	// pin change detection on every cycle, no I/O clock gating
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_prev <= epiu_pkg::RST_PINS;
		end else begin
			pc_prev <= s_pc;
		end
	end

	always_comb begin
		pc_hit = |((s_pc ^ pc_prev) & pin_change_mask);
		pc_clr = pin_change_vector_taken || (reg_write(epiu_pkg::OFF_PC_FLAGS) && reg_wdata[0]);
		next_pc_flag = (pin_change_flag && !pc_clr) || pc_hit;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_flag <= epiu_pkg::RST_BIT;
		end else begin
			pin_change_flag <= next_pc_flag;
		end
	end

	// a low level requests only while it lasts, so a level gone
	// before start-up ends leaves nothing pending
	always_comb begin
		lane_req = line_mask & ((lane_low_mode & ~lane_level) | (~lane_low_mode & ext_line_flag));
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_line_request <= epiu_pkg::RST_BYTE;
		end else begin
			ext_line_request <= lanes_to_byte(lane_req & {5{global_int_enable}});
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_request <= epiu_pkg::RST_BIT;
		end else begin
			pin_change_request <= global_int_enable && pin_change_group_enable && pin_change_flag;
		end
	end

	// wake ignores the global enable: the core decides after start-up
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_request <= epiu_pkg::RST_BIT;
		end else begin
			wake_request <= (|lane_req) || (pin_change_group_enable && pin_change_flag);
		end
	end

	// register read port, data in the following cycle
	always_comb begin
		next_rdata = epiu_pkg::RST_BYTE;
		case (reg_addr)
			epiu_pkg::OFF_SENSE_A: next_rdata = ext_sense_ctrl_a;
			epiu_pkg::OFF_SENSE_B: next_rdata = {2'b00, line_six_sense_select, 4'h0};
			epiu_pkg::OFF_LINE_MASK: next_rdata = lanes_to_byte(line_mask);
			epiu_pkg::OFF_LINE_FLAGS: next_rdata = lanes_to_byte(ext_line_flag);
			epiu_pkg::OFF_PC_CTRL: next_rdata = {7'h00, pin_change_group_enable};
			epiu_pkg::OFF_PC_FLAGS: next_rdata = {7'h00, pin_change_flag};
			epiu_pkg::OFF_PC_MASK: next_rdata = pin_change_mask;
			default: next_rdata = epiu_pkg::RST_BYTE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= epiu_pkg::RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= epiu_pkg::RST_BYTE;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence pc_toggle_s;
		|((s_pc ^ pc_prev) & pin_change_mask);
	endsequence

	// enables are judged as they stood when the request was registered
	sequence pc_flag_up_s;
		pin_change_flag ##1 (pin_change_request || !$past(global_int_enable) || !$past(pin_change_group_enable));
	endsequence

	sequence read_sense_b_s;
		reg_rd && (reg_addr == epiu_pkg::OFF_SENSE_B);
	endsequence

	sequence line0_fall_s;
		$fell(lane_level[0]) && (ext_sense_ctrl_a[1:0] == epiu_pkg::SENSE_FALL);
	endsequence

	sequence line0_rise_s;
		$rose(lane_level[0]) && (ext_sense_ctrl_a[1:0] == epiu_pkg::SENSE_RISE);
	endsequence

	sequence six_fall_s;
		io_clk_run && $past(io_clk_run) && $fell(lane_level[4]) && (line_six_sense_select == epiu_pkg::SENSE_FALL);
	endsequence

	level_flag_clr_a: assert property (lane_low_mode[0] |=> !ext_line_flag[0])
		else $error("line flag set in level mode");

	level_req_a: assert property (global_int_enable && line_mask[1] && lane_low_mode[1] && !lane_level[1]
		|=> ext_line_request[1])
		else $error("level request missing");

	global_gate_a: assert property (!global_int_enable |=> ext_line_request == 8'h00)
		else $error("line request without global enable");

	pc_gate_a: assert property (!(global_int_enable && pin_change_group_enable) |=> !pin_change_request)
		else $error("pin change request while disabled");

	pc_toggle_a: assert property (pc_toggle_s |=> pc_flag_up_s)
		else $error("pin toggle did not raise flag and request");

	pc_block_a: assert property (!pin_change_flag && !(|((s_pc ^ pc_prev) & pin_change_mask))
		|=> !pin_change_flag)
		else $error("pin change flag set by masked pin");

	flag_w1c_a: assert property (reg_wr && reg_addr == epiu_pkg::OFF_LINE_FLAGS && reg_wdata[0]
		&& !lane_hit[0] |=> !ext_line_flag[0])
		else $error("write one did not clear flag");

	set_wins_a: assert property (lane_hit[2] && !lane_low_mode[2] |=> ext_line_flag[2])
		else $error("clear beat a same-cycle set");

	six_noclk_a: assert property (!io_clk_run |-> !lane_hit[4])
		else $error("line six edge seen without io clock");

	resv_zero_a: assert property (read_sense_b_s |=> (reg_rdata[7:6] == 2'b00) && (reg_rdata[3:0] == 4'h0))
		else $error("reserved bits not zero");

	sleep_buf_a: assert property (sleep_active && !line_mask[3] |-> !lane_level[3])
		else $error("disabled line buffer not forced low");

	pin_sync_a: assert property (s_pc == $past(change_watch_pins, 2) || $past(!rst_n, 2))
		else $error("pin sync latency wrong");

	edge_req_a: assert property (!lane_low_mode[0] && ext_line_flag[0] && line_mask[0]
		&& global_int_enable |=> ext_line_request[0])
		else $error("edge flag gave no request");

	level_gone_a: assert property (lane_low_mode[0] && lane_level[0] |=> !ext_line_request[0])
		else $error("level request outlived the level");

	mask_off_a: assert property (!line_mask[1] |=> !ext_line_request[1])
		else $error("masked line requested");

	wake_level_a: assert property (line_mask[2] && lane_low_mode[2] && !lane_level[2] |=> wake_request)
		else $error("low level did not request wake");

	wake_pc_a: assert property (pin_change_group_enable && pin_change_flag |=> wake_request)
		else $error("pin change did not request wake");

	pc_req_a: assert property (global_int_enable && pin_change_group_enable && pin_change_flag
		|=> pin_change_request)
		else $error("pin change request missing");

	pc_w1c_a: assert property (reg_wr && reg_addr == epiu_pkg::OFF_PC_FLAGS && reg_wdata[0]
		&& !pc_hit |=> !pin_change_flag)
		else $error("write one did not clear pin change flag");

	pc_vec_clr_a: assert property (pin_change_vector_taken && !pc_hit |=> !pin_change_flag)
		else $error("vector did not clear pin change flag");

	line_vec_clr_a: assert property (line_vector_taken[0] && !lane_hit[0] |=> !ext_line_flag[0])
		else $error("vector did not clear line flag");

	fall_flag_a: assert property (line0_fall_s |=> ext_line_flag[0])
		else $error("falling edge missed on line zero");

	rise_flag_a: assert property (line0_rise_s |=> ext_line_flag[0])
		else $error("rising edge missed on line zero");

	six_fall_a: assert property (six_fall_s |=> ext_line_flag[4])
		else $error("line six falling edge missed");
endmodule // epiu_top
`default_nettype wire

// ==== verification/epiu_pin_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module epiu_pin_src (
	input wire logic core_clk,
	output logic [4:0] lines,
	output logic [7:0] pins
);
	// sources idle high, like pulled-up pins
	initial begin
		lines = 5'h1F;
		pins = 8'hFF;
	end
	// every level is held well over one clock and past the minimum width
	task automatic drive(input logic [4:0] l, input logic [7:0] p);
		@(posedge core_clk);
		lines <= l;
		pins <= p;
		repeat (6) @(posedge core_clk);
	endtask
endmodule // epiu_pin_src
`default_nettype wire

// ==== verification/tb_external_pin_interrupt_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_external_pin_interrupt_unit;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_q = 1'b0;
	logic gie = 1'b1;
	logic io_run = 1'b1;
	logic sleep = 1'b0;
	logic pc_vec = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] vec = 8'h00;
	logic [7:0] rdata, req, cpins, f;
	logic pc_req, wake;
	logic [4:0] lines;
	logic [4:0] l = 5'h1F;
	logic [7:0] p = 8'hFF;
	logic [1:0] s;
	logic [7:0] exp_q[$];
	logic [7:0] rw_exp [8] = '{8'hFF, 8'h30, 8'h4F, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h00};
	logic [31:0] seed = 32'h5562;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int k, n;

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	epiu_pin_src src (.core_clk(core_clk), .lines(lines), .pins(cpins));

	epiu_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .ext_lines_zero_to_three(lines[3:0]), .ext_line_six(lines[4]),
		.change_watch_pins(cpins), .global_int_enable(gie), .io_clk_run(io_run), .sleep_active(sleep),
		.line_vector_taken(vec), .pin_change_vector_taken(pc_vec), .ext_line_request(req),
		.pin_change_request(pc_req), .wake_request(wake));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_q <= reg_rd;
		if (rd_q === 1'b1) chk(rdata, exp_q.pop_front());
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic step(input int b, input logic lv, input logic [7:0] fl, input logic [7:0] rq);
		l[b] = lv;
		src.drive(l, p);
		rd(epiu_pkg::OFF_LINE_FLAGS, fl);
		@(negedge core_clk);
		chk(req, rq);
	endtask

	initial begin
		// pins held high over release: edge history resets to one
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
		for (int a = 0; a < 8; a++) wr(3'(a), 8'hFF);
		for (int a = 0; a < 8; a++) rd(3'(a), rw_exp[a]);
		for (int a = 0; a < 8; a++) wr(3'(a), 8'h00);
		$display("registers done");
		k = int'(rnd() % 32'h8);
		wr(epiu_pkg::OFF_PC_MASK, 8'h01 << k);
		wr(epiu_pkg::OFF_PC_CTRL, 8'h01);
		p = p ^ (8'h01 << k);
		src.drive(l, p);
		rd(epiu_pkg::OFF_PC_FLAGS, 8'h01);
		@(negedge core_clk);
		chk({6'h00, pc_req, wake}, 8'h03);
		wr(epiu_pkg::OFF_PC_FLAGS, 8'h01);
		p = p ^ (8'h01 << ((k + 1) % 8));
		src.drive(l, p);
		rd(epiu_pkg::OFF_PC_FLAGS, 8'h00);
		@(posedge core_clk);
		gie <= 1'b0;
		sleep <= 1'b1;
		p = p ^ (8'h01 << k);
		src.drive(l, p);
		@(negedge core_clk);
		chk({6'h00, pc_req, wake}, 8'h01);
		@(posedge core_clk);
		pc_vec <= 1'b1;
		@(posedge core_clk);
		pc_vec <= 1'b0;
		gie <= 1'b1;
		sleep <= 1'b0;
		rd(epiu_pkg::OFF_PC_FLAGS, 8'h00);
		$display("pin change done");
		for (int i = 0; i < 5; i++) begin
			n = (i == 4) ? 6 : i;
			for (int m = 0; m < 4; m++) begin
				s = 2'(m);
				wr(epiu_pkg::OFF_LINE_MASK, 8'h00);
				if (i == 4) wr(epiu_pkg::OFF_SENSE_B, 8'(s) << 4);
				else wr(epiu_pkg::OFF_SENSE_A, 8'(s) << (2 * i));
				wr(epiu_pkg::OFF_LINE_FLAGS, 8'hFF);
				wr(epiu_pkg::OFF_LINE_MASK, 8'h01 << n);
				f = (s == epiu_pkg::SENSE_ANY || s == epiu_pkg::SENSE_FALL) ? 8'h01 << n : 8'h00;
				step(i, 1'b0, f, (s == epiu_pkg::SENSE_LOW) ? 8'h01 << n : f);
				wr(epiu_pkg::OFF_LINE_FLAGS, 8'h01 << n);
				f = (s == epiu_pkg::SENSE_ANY || s == epiu_pkg::SENSE_RISE) ? 8'h01 << n : 8'h00;
				step(i, 1'b1, f, f);
				@(posedge core_clk);
				vec <= 8'h01 << n;
				@(posedge core_clk);
				vec <= 8'h00;
				rd(epiu_pkg::OFF_LINE_FLAGS, 8'h00);
			end
		end
		$display("sense modes done");
		wr(epiu_pkg::OFF_SENSE_B, 8'h20);
		@(posedge core_clk);
		io_run <= 1'b0;
		step(4, 1'b0, 8'h00, 8'h00);
		l[4] = 1'b1;
		src.drive(l, p);
		io_run <= 1'b1;
		wr(epiu_pkg::OFF_SENSE_A, 8'h02);
		wr(epiu_pkg::OFF_LINE_MASK, 8'h01);
		gie <= 1'b0;
		step(0, 1'b0, 8'h01, 8'h00);
		step(0, 1'b1, 8'h01, 8'h00);
		$display("gating done");
		repeat (2) @(posedge core_clk);
		finish_test();
	end
endmodule // tb_external_pin_interrupt_unit
`default_nettype wire
